/* core/csac_cfg_if.sv */
`timescale 1ns/1ps
// carries register writes from the bus slave to the apply logic
interface csac_cfg_if;
  logic wr; // one-cycle write strobe
  logic [5:0] addr; // byte address
  logic [31:0] wdata; // write data
  modport src (output wr, output addr, output wdata);
  modport dst (input wr, input addr, input wdata);
endinterface

/* core/csac_pkg.sv */
// What this block does
// - gain and blanking apply at once always
// - digital gain deferred; analog only from nvm
// - nvm programming starts only in standby
// - writes to read-only fields are ignored
// - status flags set by hardware only
// - write-only fields read back as zero
// - standby fields apply when enable low
// - standby field reads return written value
// - nvm-only fields load at power-up only
// - always fields apply immediately in any state
package csac_pkg;
  // ----------------------------------------
  // register word offsets (byte addresses)
  // ----------------------------------------
  localparam logic [5:0] CSAC_OFS_STATUS = 6'h00; // rh flags, r nvm
  localparam logic [5:0] CSAC_OFS_ALWAYS = 6'h04; // always fields
  localparam logic [5:0] CSAC_OFS_STBY = 6'h08; // standby fields
  localparam logic [5:0] CSAC_OFS_AMP = 6'h0C; // gain, blank, mode
  localparam logic [5:0] CSAC_OFS_NVM = 6'h10; // nvm staging
  localparam logic [5:0] CSAC_OFS_PROG = 6'h14; // write-only program
  localparam logic [5:0] CSAC_OFS_EFF = 6'h18; // effective standby
  // ----------------------------------------
  // field positions
  // ----------------------------------------
  localparam int CSAC_AMP_GAIN_LSB = 0; // gain 3 bits
  localparam int CSAC_AMP_BLANK_LSB = 4; // blank 4 bits
  localparam int CSAC_AMP_MODE_BIT = 8; // 1 analog, 0 digital
  localparam int CSAC_ST_PEND_BIT = 0; // standby write pending
  localparam int CSAC_ST_BUSY_BIT = 1; // nvm program busy
  localparam int CSAC_ST_DONE_BIT = 2; // nvm program done
  localparam int CSAC_ST_REJ_BIT = 3; // program rejected
  localparam int CSAC_ST_MODE_BIT = 4; // effective gain mode
  localparam int CSAC_ST_NVM_LSB = 16; // nvm word readback
  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [15:0] CSAC_RST_CFG = 16'h0000;
  localparam logic [15:0] CSAC_PROG_KEY = 16'hA5C3; // start code
  localparam int CSAC_PROG_NS = 1000; // nvm burn time
  localparam int CSAC_CLK_NS = 10;
  localparam int CSAC_PROG_CYC = (CSAC_PROG_NS + CSAC_CLK_NS - 1)
                                 / CSAC_CLK_NS;
  typedef enum logic [2:0] {
    CSAC_IDLE = 3'b001,
    CSAC_BURN = 3'b010,
    CSAC_DONE = 3'b100
  } csac_nvm_e;
endpackage

/* core/csac_sync.sv */
`timescale 1ns/1ps
// two-flop synchroniser for a pin level
module csac_sync (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic d_i,
  output logic q_o
);
  logic s1_r; // first stage, read only by second
  // ----------------------------------------
  // two stages
  // ----------------------------------------
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      s1_r <= 1'b0;
      q_o <= 1'b0;
    end else begin
      s1_r <= d_i;
      q_o <= s1_r;
    end
  end
endmodule

/* core/csac_top.sv */
`timescale 1ns/1ps
// configuration shadow and apply control
module csac_top
  import csac_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic driver_enable_input,
  input wire logic [15:0] hw_flags_i,
  input wire logic [15:0] nvm_word_i,
  output logic [15:0] always_cfg_o,
  output logic [15:0] stby_cfg_o,
  output logic [2:0] amp_gain_o,
  output logic [3:0] amp_blank_o,
  output logic amp_gain_mode_select,
  output logic [15:0] nvm_only_cfg_o,
  output logic nvm_program_request,
  output logic [15:0] nvm_prog_data_o
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  csac_cfg_if cfg (); // internal write carrier
  logic en_s; // synchronised driver enable
  logic ack_r; // answer phase of bus access
  logic [15:0] flags_r; // hardware status flags
  logic [15:0] stby_shadow_r; // host-visible standby value
  logic [15:0] stby_eff_r; // applied standby value
  logic stby_pend_r; // shadow not yet applied
  logic mode_req_r; // requested switch to digital
  logic mode_eff_r; // effective gain mode
  logic [15:0] nvm_stage_r; // data to burn
  logic [15:0] nvm_only_r; // loaded from nvm at power-up
  logic rej_r; // program asked while active
  logic [31:0] rd_nxt; // read mux
  csac_nvm_e nst_r; // nvm programming state
  logic [15:0] cnt_r; // burn timer
  logic pwr_up_r; // first cycle after reset
  logic done_r; // burn finished, sticky until next start
  logic [15:0] be_mask; // byte enable mask
  // ----------------------------------------
  // input synchroniser
  // ----------------------------------------
  csac_sync u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i(driver_enable_input),
    .q_o(en_s)
  );
  // decode of offset hit
  function automatic logic hit(input logic [5:0] a, input logic [5:0] o);
    return a == o;
  endfunction
  // ----------------------------------------
  // avalon slave: one wait state per access
  // ----------------------------------------
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_r;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= (avs_read | avs_write) & ~ack_r;
    end
  end
  assign be_mask = {{8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
  assign cfg.wr = avs_write & ack_r;
  assign cfg.addr = avs_address;
  assign cfg.wdata = avs_writedata;
  // ----------------------------------------
  // hardware flags
  // ----------------------------------------
  // flags hardware only
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      flags_r <= CSAC_RST_CFG;
    end else begin
      flags_r <= hw_flags_i;
    end
  end
  // ----------------------------------------
  // always fields and amplifier settings
  // ----------------------------------------
  // immediate apply
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      always_cfg_o <= CSAC_RST_CFG;
    end else if (cfg.wr && hit(cfg.addr, CSAC_OFS_ALWAYS)) begin
      always_cfg_o <= (always_cfg_o & ~be_mask) | (cfg.wdata[15:0] & be_mask);
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      amp_gain_o <= 3'h0;
      amp_blank_o <= 4'h0;
    end else if (cfg.wr && hit(cfg.addr, CSAC_OFS_AMP)
                 && avs_byteenable[0]) begin
      amp_gain_o <= cfg.wdata[CSAC_AMP_GAIN_LSB +: 3];
      amp_blank_o <= cfg.wdata[CSAC_AMP_BLANK_LSB +: 4];
    end
  end
  // ----------------------------------------
  // gain mode: digital deferred, analog by nvm
  // ----------------------------------------
  // digital deferred
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_req_r <= 1'b0;
    end else if (cfg.wr && hit(cfg.addr, CSAC_OFS_AMP)
                 && avs_byteenable[1]
                 && !cfg.wdata[CSAC_AMP_MODE_BIT]) begin
      mode_req_r <= 1'b1; // only a switch to digital is honoured
    end else if (!en_s) begin
      mode_req_r <= 1'b0;
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      mode_eff_r <= 1'b0;
    end else if (pwr_up_r) begin
      mode_eff_r <= nvm_word_i[CSAC_AMP_MODE_BIT];
    end else if (mode_req_r && !en_s) begin
      mode_eff_r <= 1'b0;
    end
  end
  assign amp_gain_mode_select = mode_eff_r;
  // ----------------------------------------
  // standby shadow
  // ----------------------------------------
  // shadow readback
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      stby_shadow_r <= CSAC_RST_CFG;
    end else if (cfg.wr && hit(cfg.addr, CSAC_OFS_STBY)) begin
      stby_shadow_r <= (stby_shadow_r & ~be_mask)
                       | (cfg.wdata[15:0] & be_mask);
    end
  end
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      stby_eff_r <= CSAC_RST_CFG;
      stby_pend_r <= 1'b0;
    end else if (cfg.wr && hit(cfg.addr, CSAC_OFS_STBY)) begin
      stby_pend_r <= 1'b1; // new write wins over the apply
    end else if (stby_pend_r && !en_s) begin
      stby_eff_r <= stby_shadow_r;
      stby_pend_r <= 1'b0;
    end
  end
  assign stby_cfg_o = stby_eff_r;
  // ----------------------------------------
  // nvm-only fields
  // ----------------------------------------
  // power-up load
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      pwr_up_r <= 1'b1;
      nvm_only_r <= CSAC_RST_CFG;
    end else begin
      pwr_up_r <= 1'b0;
      if (pwr_up_r) begin
        nvm_only_r <= nvm_word_i;
      end
    end
  end
  assign nvm_only_cfg_o = nvm_only_r;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      nvm_stage_r <= CSAC_RST_CFG;
    end else if (cfg.wr && hit(cfg.addr, CSAC_OFS_NVM)) begin
      nvm_stage_r <= (nvm_stage_r & ~be_mask) | (cfg.wdata[15:0] & be_mask);
    end
  end
  // ----------------------------------------
  // nvm programming sequencer
  // ----------------------------------------
  // program in standby
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      nst_r <= CSAC_IDLE;
      cnt_r <= 16'h0000;
      rej_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      unique case (nst_r)
        CSAC_IDLE: begin
          if (cfg.wr && hit(cfg.addr, CSAC_OFS_PROG)
              && cfg.wdata[15:0] == CSAC_PROG_KEY) begin
            if (!en_s) begin
              nst_r <= CSAC_BURN;
              cnt_r <= 16'(CSAC_PROG_CYC - 1);
              rej_r <= 1'b0;
              done_r <= 1'b0;
            end else begin
              rej_r <= 1'b1; // refused while driving
            end
          end
        end
        CSAC_BURN: begin
          if (cnt_r == 16'h0000) begin
            nst_r <= CSAC_DONE;
            done_r <= 1'b1; // held so the host can poll it
          end else begin
            cnt_r <= cnt_r - 16'h0001;
          end
        end
        CSAC_DONE: begin
          nst_r <= CSAC_IDLE;
        end
      endcase
    end
  end
  assign nvm_program_request = (nst_r == CSAC_BURN);
  assign nvm_prog_data_o = nvm_stage_r;
  // ----------------------------------------
  // read mux
  // ----------------------------------------
  // write-only reads zero
  always_comb begin
    rd_nxt = 32'h0000_0000;
    unique case (avs_address)
      CSAC_OFS_STATUS: begin
        rd_nxt = {nvm_only_r, flags_r};
      end
      CSAC_OFS_ALWAYS: begin
        rd_nxt = {16'h0000, always_cfg_o};
      end
      CSAC_OFS_STBY: begin
        rd_nxt = {16'h0000, stby_shadow_r};
      end
      CSAC_OFS_AMP: begin
        rd_nxt = {23'h000000, mode_eff_r, amp_blank_o, 1'b0,
                  amp_gain_o};
      end
      CSAC_OFS_NVM: begin
        rd_nxt = {16'h0000, nvm_stage_r};
      end
      CSAC_OFS_EFF: begin
        rd_nxt = {11'h000, mode_eff_r, rej_r, done_r,
                  nvm_program_request, stby_pend_r, stby_eff_r};
      end
      default: begin
        rd_nxt = 32'h0000_0000; // includes write-only program word
      end
    endcase
  end
  // read data taken in the wait state
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && !ack_r) begin
      avs_readdata <= rd_nxt;
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  // no apply while enabled
  property p_stby_hold;
    @(posedge ref_clk_i) disable iff (rst_i)
      en_s && $past(en_s) |-> $stable(stby_eff_r);
  endproperty
  a_stby_hold: assert property (p_stby_hold)
    else $error("standby value applied while enabled");
  property p_shadow;
    @(posedge ref_clk_i) disable iff (rst_i)
      cfg.wr && hit(cfg.addr, CSAC_OFS_STBY) && avs_byteenable == 4'hF
      |=> stby_shadow_r == $past(cfg.wdata[15:0]);
  endproperty
  a_shadow: assert property (p_shadow)
    else $error("shadow missed write");
  property p_burn;
    @(posedge ref_clk_i) disable iff (rst_i)
      $rose(nvm_program_request) |-> !$past(en_s);
  endproperty
  a_burn: assert property (p_burn)
    else $error("programming started while enabled");
  property p_nvm_fixed;
    @(posedge ref_clk_i) disable iff (rst_i)
      !pwr_up_r && !$past(pwr_up_r) |-> $stable(nvm_only_r);
  endproperty
  a_nvm_fixed: assert property (p_nvm_fixed)
    else $error("nvm-only field changed after power-up");
  property p_mode;
    @(posedge ref_clk_i) disable iff (rst_i)
      !$past(pwr_up_r) && !pwr_up_r |-> !$rose(mode_eff_r);
  endproperty
  a_mode: assert property (p_mode)
    else $error("analog mode entered by write");
  property p_always;
    @(posedge ref_clk_i) disable iff (rst_i)
      cfg.wr && hit(cfg.addr, CSAC_OFS_ALWAYS) && avs_byteenable == 4'hF
      |=> always_cfg_o == $past(cfg.wdata[15:0]);
  endproperty
  a_always: assert property (p_always)
    else $error("always field not applied");
  property p_wo;
    @(posedge ref_clk_i) disable iff (rst_i)
      avs_read && !ack_r && avs_address == CSAC_OFS_PROG
      |=> avs_readdata == 32'h0000_0000;
  endproperty
  a_wo: assert property (p_wo)
    else $error("write-only field read nonzero");
  property p_gain;
    @(posedge ref_clk_i) disable iff (rst_i)
      cfg.wr && hit(cfg.addr, CSAC_OFS_AMP) && avs_byteenable[0]
      |=> amp_gain_o == $past(cfg.wdata[2:0]);
  endproperty
  a_gain: assert property (p_gain)
    else $error("gain not applied at once");
endmodule

/* verif/csac_host.sv */
`timescale 1ns/1ps
// host controller model, avalon master to the register bank
module csac_host (
  input wire logic ref_clk_i,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  output logic [5:0] avs_address,
  output logic avs_read,
  output logic avs_write,
  output logic [31:0] avs_writedata,
  output logic [3:0] avs_byteenable
);
  // idle bus at time zero
  initial begin
    avs_address = 6'h3F;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
  end
  // ----------------------------------------
  // one transfer, held until waitrequest low
  // ----------------------------------------
  task automatic xfer(input logic wr, input logic [5:0] a,
                      input logic [31:0] d, output logic [31:0] q);
    @(posedge ref_clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= ~wr;
    // no timeout here: a hung wait is ended only by the bench watchdog
    do @(posedge ref_clk_i); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    // released lines show the inverse, never stale data
    avs_address <= ~a;
    avs_writedata <= ~d;
  endtask
endmodule

/* verif/testbench.sv */
`timescale 1ns/1ps
// self-checking bench for the shadow and apply control
module testbench;
  import csac_pkg::*;
  typedef struct packed {
    logic [5:0] a;
    logic [31:0] d;
    logic [31:0] m;
    logic [31:0] e;
  } csac_row_s;
  logic ref_clk_i = 1'b0; // 100 mhz clock
  logic rst_i = 1'b1; // sync reset
  logic driver_enable_input = 1'b0; // driver enable pin
  logic [15:0] hw_flags_i = 16'h1234; // status flags
  logic [15:0] nvm_word_i = 16'hFFFF; // nvm contents
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [15:0] always_cfg_o;
  logic [15:0] stby_cfg_o;
  logic [2:0] amp_gain_o;
  logic [3:0] amp_blank_o;
  logic amp_gain_mode_select;
  logic [15:0] nvm_only_cfg_o;
  logic nvm_program_request;
  logic [15:0] nvm_prog_data_o;
  int errors = 0;
  int samples_checked = 0;
  logic [31:0] q;
  int n;
  // ordinary cases: address, data, read mask, expected read
  csac_row_s rows [8] = '{
    '{6'h00, 32'hFFFFFFFF, 32'h0000FFFF, 32'h00001234},
    '{6'h04, 32'h00005A5A, 32'h0000FFFF, 32'h00005A5A},
    '{6'h08, 32'h0000C33C, 32'h0000FFFF, 32'h0000C33C},
    '{6'h0C, 32'h000000F5, 32'h000000FF, 32'h000000F5},
    '{6'h10, 32'h00009669, 32'h0000FFFF, 32'h00009669},
    '{6'h14, 32'h0000A5C3, 32'hFFFFFFFF, 32'h00000000},
    '{6'h18, 32'hFFFFFFFF, 32'h0000FFFF, 32'h00000000},
    '{6'h3C, 32'h12345678, 32'hFFFFFFFF, 32'h00000000}
  };
  // clock generator
  always #5 ref_clk_i = ~ref_clk_i;
  csac_top csac_top_inst (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i),
    .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest),
    .driver_enable_input(driver_enable_input),
    .hw_flags_i(hw_flags_i), .nvm_word_i(nvm_word_i),
    .always_cfg_o(always_cfg_o), .stby_cfg_o(stby_cfg_o),
    .amp_gain_o(amp_gain_o), .amp_blank_o(amp_blank_o),
    .amp_gain_mode_select(amp_gain_mode_select),
    .nvm_only_cfg_o(nvm_only_cfg_o),
    .nvm_program_request(nvm_program_request),
    .nvm_prog_data_o(nvm_prog_data_o)
  );
  csac_host csac_host_inst (
    .ref_clk_i(ref_clk_i), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable)
  );
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic check(input string nm, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] x;
    csac_host_inst.xfer(1'b1, a, d, x);
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d);
    csac_host_inst.xfer(1'b0, a, 32'h0, d);
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog against a hung handshake
  initial begin
    #300000;
    errors++;
    results();
  end
  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    check("nvm_only", {16'h0, nvm_only_cfg_o}, 32'h0000FFFF);
    check("mode_boot", {31'h0, amp_gain_mode_select}, 32'h1);
    driver_enable_input <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    for (int i = 0; i < 8; i++) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, q);
      check("row_read", q & rows[i].m, rows[i].e);
    end
    @(posedge ref_clk_i);
    check("always", {16'h0, always_cfg_o}, 32'h00005A5A);
    check("gain", {29'h0, amp_gain_o}, 32'h5);
    check("blank", {28'h0, amp_blank_o}, 32'hF);
    check("stby_held", {16'h0, stby_cfg_o}, 32'h0);
    check("prog_refused", {31'h0, nvm_program_request}, 32'h0);
    check("mode_held", {31'h0, amp_gain_mode_select}, 32'h1);
    check("nvm_kept", {16'h0, nvm_only_cfg_o}, 32'h0000FFFF);
    rd(6'h18, q);
    check("pend", {31'h0, q[16]}, 32'h1);
    check("rej", {31'h0, q[19]}, 32'h1);
    hw_flags_i <= 16'h00A5;
    repeat (3) @(posedge ref_clk_i);
    rd(6'h00, q);
    check("flags", q & 32'h0000FFFF, 32'h000000A5);
    // standby: held writes land once the enable is low
    driver_enable_input <= 1'b0;
    n = 0;
    while (stby_cfg_o !== 16'hC33C && n < 10) begin
      @(posedge ref_clk_i);
      n++;
    end
    check("stby_apply", {16'h0, stby_cfg_o}, 32'h0000C33C);
    check("mode_digital", {31'h0, amp_gain_mode_select}, 32'h0);
    wr(6'h0C, 32'h000001F5);
    repeat (3) @(posedge ref_clk_i);
    check("mode_no_ana", {31'h0, amp_gain_mode_select}, 32'h0);
    // programming accepted in standby
    wr(6'h14, {16'h0, CSAC_PROG_KEY});
    n = 0;
    while (nvm_program_request !== 1'b1 && n < 10) begin
      @(posedge ref_clk_i);
      n++;
    end
    n = 0;
    while (nvm_program_request === 1'b1 && n < 300) begin
      @(posedge ref_clk_i);
      n++;
    end
    check("burn_len", n, CSAC_PROG_CYC);
    check("prog_data", {16'h0, nvm_prog_data_o}, 32'h00009669);
    rd(6'h18, q);
    check("done", {31'h0, q[18]}, 32'h1);
    check("nvm_no_wr", {16'h0, nvm_only_cfg_o}, 32'h0000FFFF);
    // second reset: nvm fields reload at power-up
    nvm_word_i <= 16'h0F0F;
    rst_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    check("rst_always", {16'h0, always_cfg_o}, 32'h0);
    check("rst_stby", {16'h0, stby_cfg_o}, 32'h0);
    rst_i <= 1'b0;
    repeat (3) @(posedge ref_clk_i);
    check("nvm_reload", {16'h0, nvm_only_cfg_o}, 32'h00000F0F);
    results();
  end
endmodule
